// [design/cce_pkg.sv]
// package of constants, types and helpers for the call/clear/complement execution unit
package cce_pkg;
   // quarter-cycle timing: one instruction cycle is four quarters
   localparam int CLK_MHZ = 40;
   localparam int QTR_NS = 25;
   localparam int QTR_CLKS = (QTR_NS * CLK_MHZ + 999) / 1000;
   localparam int NOP_QTRS = 4;
   // apb byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STAT = 8'h04;
   localparam logic [7:0] OFS_IW0 = 8'h08;
   localparam logic [7:0] OFS_IW1 = 8'h0C;
   localparam logic [7:0] OFS_PC = 8'h10;
   localparam logic [7:0] OFS_TOS = 8'h14;
   localparam logic [7:0] OFS_ACC = 8'h18;
   localparam logic [7:0] OFS_FLG = 8'h1C;
   localparam logic [7:0] OFS_RST = 8'h20;
   localparam logic [7:0] OFS_BSR = 8'h24;
   localparam logic [7:0] OFS_SHD = 8'h28;
   localparam logic [7:0] OFS_FSR = 8'h2C;
   localparam logic [7:0] OFS_WDT = 8'h30;
   // field positions
   localparam int CTRL_GO = 0;
   localparam int CTRL_EXT = 1;
   localparam int STAT_BUSY = 0;
   localparam int STAT_BAD = 1;
   localparam int STAT_STKFUL = 2;
   localparam int FLG_Z = 2;
   localparam int FLG_N = 4;
   localparam int RST_PD = 2;
   localparam int RST_TO = 3;
   // reset values
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic [7:0] FLG_RST = 8'h00;
   localparam logic [20:0] PC_RST = 21'h000000;
   localparam logic TO_RST = 1'b1;
   localparam logic PD_RST = 1'b1;
   // program counter steps and stack
   localparam logic [20:0] PC_STEP = 21'h000002;
   localparam logic [20:0] CALL_STEP = 21'h000004;
   localparam int STK_DEPTH = 31;
   // addressing
   localparam logic [7:0] IDX_LIM = 8'h5F;
   localparam logic [3:0] ACC_HI_BANK = 4'hF;
   // opcode patterns
   localparam logic [6:0] PAT_CALL = 7'h76;
   localparam logic [3:0] PAT_CALL2 = 4'hF;
   localparam logic [6:0] PAT_ZERO = 7'h35;
   localparam logic [5:0] PAT_INV = 6'h07;
   localparam logic [15:0] PAT_KICK = 16'h0004;

   typedef enum logic [2:0] {
      OP_BAD = 3'h0,
      OP_CALL = 3'h1,
      OP_ZERO = 3'h2,
      OP_KICK = 3'h3,
      OP_INV = 3'h4
   } cce_op_t;

   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_Q1 = 6'h02,
      ST_Q2 = 6'h04,
      ST_Q3 = 6'h08,
      ST_Q4 = 6'h10,
      ST_NOP = 6'h20
   } cce_st_t;

   // file register port toward data memory
   typedef struct packed {
      logic [11:0] addr;
      logic re;
      logic we;
      logic [7:0] wdata;
   } cce_fr_t;

   // classify the first word, second word needed only for a call
   function automatic cce_op_t cce_decode(input logic [15:0] iw0, input logic [15:0] iw1);
      cce_op_t op;
      op = OP_BAD;
      if (iw0[15:9] == PAT_CALL && iw1[15:12] == PAT_CALL2) op = OP_CALL;
      else if (iw0[15:9] == PAT_ZERO) op = OP_ZERO;
      else if (iw0[15:10] == PAT_INV) op = OP_INV;
      else if (iw0 == PAT_KICK) op = OP_KICK;
      return op;
   endfunction : cce_decode

   // effective file address from access bit, bank and extended mode
   function automatic logic [11:0] cce_ea(input logic [7:0] f, input logic a,
                                          input logic ext, input logic [3:0] bank_select_reg,
                                          input logic [11:0] fsr2);
      logic [11:0] ea;
      ea = {bank_select_reg, f};
      if (!a) begin
         if (ext && f <= IDX_LIM) ea = fsr2 + {4'h0, f};
         else if (f <= IDX_LIM) ea = {4'h0, f};
         else ea = {ACC_HI_BANK, f};
      end
      return ea;
   endfunction : cce_ea
endpackage : cce_pkg

// [design/cce_wdog.sv]
// watchdog counter with postscaler, cleared by the kick instruction
`timescale 1ns/10ps
module cce_wdog
   import cce_pkg::*;
(
   input wire logic clock,
   input wire logic rstn,
   input wire logic tick,
   input wire logic kick,
   output logic [7:0] cnt_q,
   output logic [3:0] post_q,
   output logic expire_q
);
   // count on instruction ticks; kick wins over counting so no expiry slips through
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cnt_q <= 8'h00;
         post_q <= 4'h0;
         expire_q <= 1'b0;
      end else begin
         expire_q <= 1'b0;
         if (kick) begin
            cnt_q <= 8'h00;
            post_q <= 4'h0;
         end else if (tick) begin
            cnt_q <= cnt_q + 8'h01;
            if (cnt_q == 8'hFF) begin
               post_q <= post_q + 4'h1;
               expire_q <= (post_q == 4'hF);
            end
         end
      end
   end
endmodule : cce_wdog

// [design/cce_exec.sv]
// execution unit for call, clear-file, watchdog-kick and complement-file instructions
//
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/10ps
module cce_exec
   import cce_pkg::*;
(
   input wire logic clock,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata_q,
   output logic pready_q,
   output logic pslverr_q,
   output cce_fr_t fr_q,
   input wire logic [7:0] fr_rdata
);
   ////////////////////////////////////////////////////////////////////////////
   logic [3:0] qdiv_q;
   logic qtick_q;
   cce_st_t st_q;
   cce_op_t op_q;
   logic [1:0] nopc_q;
   logic go_q;
   logic bad_q;
   logic ext_q;
   logic [15:0] iw0_q;
   logic [15:0] iw1_q;
   logic [20:0] pc_q;
   logic [7:0] w_q;
   logic [7:0] flg_q;
   logic [3:0] bsr_q;
   logic [11:0] fsr2_q;
   logic [7:0] ws_q;
   logic [7:0] fs_q;
   logic [3:0] bs_q;
   logic to_q;
   logic pd_q;
   logic [11:0] ea_q;
   logic [7:0] lo_q;
   logic [7:0] rd_q;
   logic [20:0] stk_q [0:STK_DEPTH-1];
   logic [4:0] sp_q;
   logic [7:0] wcnt;
   logic [3:0] wpost;
   logic wexp;
   logic wtick;
   logic acc;
   logic wr;
   logic idle;
   logic t_q1, t_q2, t_q3, t_q4;
   logic kick;
   logic [20:0] return_stack_head;
   logic [7:0] res;
   logic [31:0] rdata_d;
   logic mapped_d;

   assign acc = psel && penable && pready_q;
   assign wr = acc && pwrite;
   assign idle = (st_q == ST_IDLE);
   assign t_q1 = qtick_q && st_q == ST_Q1;
   assign t_q2 = qtick_q && st_q == ST_Q2;
   assign t_q3 = qtick_q && st_q == ST_Q3;
   assign t_q4 = qtick_q && st_q == ST_Q4;
   assign kick = t_q3 && op_q == OP_KICK;
   assign return_stack_head = (sp_q == 5'd0) ? PC_RST : stk_q[sp_q - 5'd1];
   assign res = ~rd_q;

   ////////////////////////////////////////////////////////////////////////////
   // quarter-cycle enable from a divider
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         qdiv_q <= 4'h0;
         qtick_q <= 1'b0;
      end else begin
         qtick_q <= (qdiv_q == 4'(QTR_CLKS - 1));
         qdiv_q <= (qdiv_q == 4'(QTR_CLKS - 1)) ? 4'h0 : qdiv_q + 4'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // apb slave: zero wait states, read data captured in setup
   always_comb begin
      rdata_d = 32'h0000_0000;
      mapped_d = 1'b1;
      unique case (paddr)
         OFS_CTRL: rdata_d = {30'h0, ext_q, go_q};
         OFS_STAT: rdata_d = {29'h0, sp_q == 5'(STK_DEPTH), bad_q, !idle || go_q};
         OFS_IW0: rdata_d = {16'h0, iw0_q};
         OFS_IW1: rdata_d = {16'h0, iw1_q};
         OFS_PC: rdata_d = {11'h0, pc_q};
         OFS_TOS: rdata_d = {11'h0, return_stack_head};
         OFS_ACC: rdata_d = {24'h0, w_q};
         OFS_FLG: rdata_d = {24'h0, flg_q};
         OFS_RST: rdata_d = {28'h0, to_q, pd_q, 2'b00};
         OFS_BSR: rdata_d = {28'h0, bsr_q};
         OFS_SHD: rdata_d = {12'h0, bs_q, fs_q, ws_q};
         OFS_FSR: rdata_d = {20'h0, fsr2_q};
         OFS_WDT: rdata_d = {20'h0, wpost, wcnt};
         default: mapped_d = 1'b0;
      endcase
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         pready_q <= psel && !penable && !pready_q;
         if (psel && !penable) begin
            prdata_q <= pwrite ? 32'h0000_0000 : rdata_d;
            pslverr_q <= !mapped_d || (paddr[1:0] != 2'b00);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // instruction words, mode and start request; software changes only while idle
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         iw0_q <= 16'h0000;
         iw1_q <= 16'h0000;
         ext_q <= 1'b0;
         go_q <= 1'b0;
      end else begin
         if (idle && !go_q && wr) begin
            if (paddr == OFS_IW0) iw0_q <= pwdata[15:0];
            if (paddr == OFS_IW1) iw1_q <= pwdata[15:0];
            if (paddr == OFS_CTRL) begin
               ext_q <= pwdata[CTRL_EXT];
               go_q <= pwdata[CTRL_GO];
            end
         end else if (go_q && qtick_q && idle) begin
            go_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sequencer: four quarters, plus a dead cycle after a call
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         st_q <= ST_IDLE;
         op_q <= OP_BAD;
         nopc_q <= 2'd0;
      end else if (qtick_q) begin
         unique case (st_q)
            ST_IDLE: if (go_q) st_q <= ST_Q1;
            ST_Q1: begin
               op_q <= cce_decode(iw0_q, iw1_q);
               st_q <= ST_Q2;
            end
            ST_Q2: st_q <= ST_Q3;
            ST_Q3: st_q <= ST_Q4;
            ST_Q4: begin
               nopc_q <= 2'd0;
               st_q <= (op_q == OP_CALL) ? ST_NOP : ST_IDLE;
            end
            ST_NOP: begin
               nopc_q <= nopc_q + 2'd1;
               if (nopc_q == 2'(NOP_QTRS - 1)) st_q <= ST_IDLE;
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // address, literal and operand capture
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ea_q <= 12'h000;
         lo_q <= 8'h00;
         rd_q <= 8'h00;
         bad_q <= 1'b0;
      end else begin
         if (t_q1) ea_q <= cce_ea(iw0_q[7:0], iw0_q[8], ext_q, bsr_q, fsr2_q);
         if (t_q2) lo_q <= iw0_q[7:0];
         if (t_q3) rd_q <= fr_rdata;
         if (t_q1) bad_q <= 1'b0;
         if (t_q4 && op_q == OP_BAD) bad_q <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // file register port: read in q2, write in q4, silent in the dead cycle
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         fr_q <= '0;
      end else begin
         fr_q.we <= 1'b0;
         if (t_q2 && (op_q == OP_ZERO || op_q == OP_INV)) begin
            fr_q.addr <= ea_q;
            fr_q.re <= 1'b1;
         end
         if (t_q3) fr_q.re <= 1'b0;
         if (t_q4 && op_q == OP_ZERO) begin
            fr_q.we <= 1'b1;
            fr_q.wdata <= 8'h00;
         end
         if (t_q4 && op_q == OP_INV && iw0_q[9]) begin
            fr_q.we <= 1'b1;
            fr_q.wdata <= res;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // return stack: push happens in q3, before the target load in q4
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         sp_q <= 5'd0;
      end else if (t_q3 && op_q == OP_CALL && sp_q != 5'(STK_DEPTH)) begin
         sp_q <= sp_q + 5'd1;
      end
   end

   // overflow drops the push; a full stack is flagged in the status word
   always_ff @(posedge clock) begin
      if (t_q3 && op_q == OP_CALL && sp_q != 5'(STK_DEPTH)) begin
         stk_q[sp_q] <= pc_q + CALL_STEP;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // program counter
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pc_q <= PC_RST;
      end else if (t_q4) begin
         if (op_q == OP_CALL) pc_q <= {iw1_q[11:0], lo_q, 1'b0};
         else pc_q <= pc_q + PC_STEP;
      end else if (idle && !go_q && wr && paddr == OFS_PC) begin
         pc_q <= {pwdata[20:1], 1'b0};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // accumulator, flags, bank select and indirect pointer
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         w_q <= ACC_RST;
         flg_q <= FLG_RST;
         bsr_q <= 4'h0;
         fsr2_q <= 12'h000;
      end else if (t_q4 && op_q == OP_ZERO) begin
         flg_q[FLG_Z] <= 1'b1;
      end else if (t_q4 && op_q == OP_INV) begin
         if (!iw0_q[9]) w_q <= res;
         flg_q[FLG_N] <= res[7];
         flg_q[FLG_Z] <= (res == 8'h00);
      end else if (idle && !go_q && wr) begin
         if (paddr == OFS_ACC) w_q <= pwdata[7:0];
         if (paddr == OFS_FLG) flg_q <= pwdata[7:0];
         if (paddr == OFS_BSR) bsr_q <= pwdata[3:0];
         if (paddr == OFS_FSR) fsr2_q <= pwdata[11:0];
      end
   end

   // shadows change only on a fast-save call
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ws_q <= 8'h00;
         fs_q <= 8'h00;
         bs_q <= 4'h0;
      end else if (t_q4 && op_q == OP_CALL && iw0_q[8]) begin
         ws_q <= w_q;
         fs_q <= flg_q;
         bs_q <= bsr_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // reset-cause flags: kick sets both, watchdog expiry clears time-out
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         to_q <= TO_RST;
         pd_q <= PD_RST;
      end else if (kick) begin
         to_q <= 1'b1;
         pd_q <= 1'b1;
      end else if (wexp) begin
         to_q <= 1'b0;
      end else if (idle && !go_q && wr && paddr == OFS_RST) begin
         to_q <= pwdata[RST_TO];
         pd_q <= pwdata[RST_PD];
      end
   end

   // kick cycle not counted, so the counter still reads zero once the kick retires
   assign wtick = t_q4 && op_q != OP_KICK;

   // watchdog advances once per executed instruction other than a kick, in its q4
   cce_wdog u_wdog (
      .clock(clock),
      .rstn(rstn),
      .tick(wtick),
      .kick(kick),
      .cnt_q(wcnt),
      .post_q(wpost),
      .expire_q(wexp)
   );

   ////////////////////////////////////////////////////////////////////////////
   // checks
   AST_CALL_PUSH: assert property (@(posedge clock) disable iff (!rstn)
      (t_q3 && op_q == OP_CALL && sp_q == 5'd0) |=> (return_stack_head == $past(pc_q) + CALL_STEP))
      else $error("call did not push pc plus four");
   AST_SHADOW_COPY: assert property (@(posedge clock) disable iff (!rstn)
      (t_q4 && op_q == OP_CALL && iw0_q[8]) |=> (ws_q == w_q && fs_q == flg_q && bs_q == bsr_q))
      else $error("fast-save shadows not copied");
   AST_SHADOW_HOLD: assert property (@(posedge clock) disable iff (!rstn)
      (t_q4 && op_q == OP_CALL && !iw0_q[8]) |=> $stable(ws_q) && $stable(fs_q) && $stable(bs_q))
      else $error("shadows changed without fast-save");
   AST_CALL_TARGET: assert property (@(posedge clock) disable iff (!rstn)
      (t_q4 && op_q == OP_CALL) |=> (pc_q == {iw1_q[11:0], iw0_q[7:0], 1'b0}))
      else $error("call target not loaded");
   AST_CALL_DEAD: assert property (@(posedge clock) disable iff (!rstn)
      (t_q4 && op_q == OP_CALL) |=> (st_q == ST_NOP && !fr_q.we && !fr_q.re) [*4] ##1 idle)
      else $error("call second cycle not idle for four quarters");
   AST_ZERO_WRITE: assert property (@(posedge clock) disable iff (!rstn)
      (t_q4 && op_q == OP_ZERO) |=> fr_q.we && fr_q.wdata == 8'h00 && flg_q[FLG_Z] ##1 !fr_q.we)
      else $error("clear-file write missing");
   AST_BANKED: assert property (@(posedge clock) disable iff (!rstn)
      (t_q2 && op_q == OP_ZERO && iw0_q[8]) |=> (fr_q.addr == {bsr_q, iw0_q[7:0]} && fr_q.re))
      else $error("banked address wrong");
   AST_INDEXED: assert property (@(posedge clock) disable iff (!rstn)
      (t_q2 && (op_q == OP_ZERO || op_q == OP_INV)
      && !iw0_q[8] && ext_q && iw0_q[7:0] <= IDX_LIM)
      |=> (fr_q.addr == fsr2_q + {4'h0, iw0_q[7:0]}))
      else $error("indexed address wrong");
   AST_KICK: assert property (@(posedge clock) disable iff (!rstn)
      kick |=> (to_q && pd_q && wcnt == 8'h00 && wpost == 4'h0 && $stable(flg_q)))
      else $error("watchdog kick effects wrong");
   AST_INV_DEST: assert property (@(posedge clock) disable iff (!rstn)
      (t_q4 && op_q == OP_INV && !iw0_q[9]) |=> (w_q == ~$past(rd_q) && !fr_q.we))
      else $error("complement to accumulator wrong");
   AST_INV_FLAGS: assert property (@(posedge clock) disable iff (!rstn)
      (t_q4 && op_q == OP_INV) |=> (flg_q[FLG_Z] == (fr_q.we ? fr_q.wdata == 8'h00 : w_q == 8'h00)
      && flg_q[3:0] == {$past(flg_q[3]), flg_q[FLG_Z], $past(flg_q[1:0])}))
      else $error("complement flags wrong");
   COV_CALL_FAST: cover property (@(posedge clock) disable iff (!rstn)
      t_q4 && op_q == OP_CALL && iw0_q[8]);
   COV_ZERO: cover property (@(posedge clock) disable iff (!rstn) t_q4 && op_q == OP_ZERO);
   COV_INV_FILE: cover property (@(posedge clock) disable iff (!rstn)
      t_q4 && op_q == OP_INV && iw0_q[9]);
   COV_KICK: cover property (@(posedge clock) disable iff (!rstn) kick);
endmodule : cce_exec

// [verif/tb_top.sv]
// self-checking bench for the call/clear/complement execution unit
`timescale 1ns/10ps
module tb_top;
   import cce_pkg::*;
   logic clock, rstn, psel, penable, pwrite, pready_q, pslverr_q, err;
   logic [7:0] paddr, fr_rdata;
   logic [31:0] pwdata, prdata_q, rd;
   cce_fr_t fr_q;
   logic [7:0] mem [0:4095];
   logic [20:0] epc;
   int fails, cmp_count, nre;

   cce_exec i_cce_exec (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q),
      .pready_q(pready_q), .pslverr_q(pslverr_q), .fr_q(fr_q), .fr_rdata(fr_rdata));

   ////////////////////////////////////////////////////////////////////////////
   // file memory stand-in: read data follows the address with no delay
   assign fr_rdata = mem[fr_q.addr];
   // writes land on the strobe edge, reads counted to spot stray accesses
   always @(posedge clock) begin
      if (fr_q.we === 1'b1) mem[fr_q.addr] <= fr_q.wdata;
      if (fr_q.re === 1'b1) nre++;
   end

   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic results;
      $display("checks %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : results

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // one apb transfer; request held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge clock);
         if (pready_q === 1'b1) break;
      end
      rd = prdata_q;
      err = pslverr_q;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 20) begin
         fails++;
         results();
      end
      @(posedge clock);
   endtask : apb

   task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rd);
   endtask : rdchk

   // load words, start, then poll busy with a bound
   task automatic run(input logic [15:0] w0, input logic [15:0] w1, input logic ext);
      int n;
      apb(1'b1, OFS_IW0, {16'h0, w0});
      apb(1'b1, OFS_IW1, {16'h0, w1});
      apb(1'b1, OFS_CTRL, {30'h0, ext, 1'b1});
      for (n = 0; n < 40; n++) begin
         apb(1'b0, OFS_STAT, 32'h0);
         if (rd[STAT_BUSY] === 1'b0) break;
      end
      if (n == 40) begin
         fails++;
         results();
      end
   endtask : run

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      rdchk("pc", OFS_PC, 32'h0);
      rdchk("acc", OFS_ACC, 32'h0);
      rdchk("flags", OFS_FLG, 32'h0);
      rdchk("status", OFS_RST, 32'h0000000C);
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, err});
   endtask : t_reset

   // two calls: fast save on, then off with a new accumulator
   task automatic t_call;
      int n0;
      apb(1'b1, OFS_ACC, 32'h5A);
      apb(1'b1, OFS_FLG, 32'h10);
      apb(1'b1, OFS_BSR, 32'h3);
      n0 = nre;
      run(16'hED34, 16'hFABC, 1'b0);
      chk("call file reads", n0, nre);
      epc = {20'hABC34, 1'b0};
      rdchk("pc call", OFS_PC, {11'h0, epc});
      rdchk("tos call", OFS_TOS, 32'h4);
      rdchk("shadow save", OFS_SHD, 32'h0003105A);
      apb(1'b1, OFS_ACC, 32'h11);
      run(16'hEC78, 16'hF012, 1'b0);
      rdchk("tos second", OFS_TOS, {11'h0, epc + CALL_STEP});
      epc = {20'h01278, 1'b0};
      rdchk("pc second", OFS_PC, {11'h0, epc});
      rdchk("shadow kept", OFS_SHD, 32'h0003105A);
   endtask : t_call

   // clear through every addressing path, including the indexed boundary
   task automatic t_zero;
      logic [7:0] fs [5] = '{8'h40, 8'h20, 8'h80, 8'h5F, 8'h60};
      logic as [5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
      logic xs [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
      logic [11:0] ea [5] = '{12'h340, 12'h020, 12'hF80, 12'h25F, 12'hF60};
      for (int i = 0; i < 5; i++) begin
         mem[ea[i]] = 8'hA5;
         apb(1'b1, OFS_FSR, 32'h200);
         apb(1'b1, OFS_FLG, 32'h0);
         run({7'h35, as[i], fs[i]}, 16'h0, xs[i]);
         chk("cleared cell", 32'h0, {24'h0, mem[ea[i]]});
         rdchk("zero flag", OFS_FLG, 32'h04);
         epc = epc + PC_STEP;
         rdchk("pc clear", OFS_PC, {11'h0, epc});
      end
   endtask : t_zero

   // complement to file then to accumulator; carry bit must survive
   task automatic t_inv;
      mem[12'h322] = 8'h0F;
      mem[12'h323] = 8'hFF;
      apb(1'b1, OFS_ACC, 32'h33);
      apb(1'b1, OFS_FLG, 32'h01);
      run(16'h1F22, 16'h0, 1'b0);
      chk("inverted cell", 32'hF0, {24'h0, mem[12'h322]});
      rdchk("acc kept", OFS_ACC, 32'h33);
      rdchk("flags neg", OFS_FLG, 32'h11);
      run(16'h1D23, 16'h0, 1'b0);
      rdchk("acc inverted", OFS_ACC, 32'h0);
      chk("cell kept", 32'hFF, {24'h0, mem[12'h323]});
      rdchk("flags zero", OFS_FLG, 32'h05);
      epc = epc + 21'h4;
      rdchk("pc invert", OFS_PC, {11'h0, epc});
   endtask : t_inv

   task automatic t_kick;
      apb(1'b1, OFS_RST, 32'h0);
      apb(1'b1, OFS_FLG, 32'h14);
      run(PAT_KICK, 16'h0, 1'b0);
      rdchk("watchdog", OFS_WDT, 32'h0);
      rdchk("expiry and sleep", OFS_RST, 32'h0000000C);
      rdchk("flags untouched", OFS_FLG, 32'h14);
      epc = epc + PC_STEP;
   endtask : t_kick

   task automatic t_bad;
      run(16'hFFFF, 16'h0, 1'b0);
      chk("bad flag", 32'h1, {31'h0, rd[STAT_BAD]});
      epc = epc + PC_STEP;
      rdchk("pc bad", OFS_PC, {11'h0, epc});
   endtask : t_bad

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      rstn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      fails = 0;
      cmp_count = 0;
      nre = 0;
      epc = 21'h0;
      for (int i = 0; i < 4096; i++) mem[i] = 8'h00;
      repeat (20) @(posedge clock);
      rstn <= 1'b1;
      @(posedge clock);
      t_reset();
      t_call();
      t_zero();
      t_inv();
      t_kick();
      t_bad();
      results();
   end
endmodule : tb_top
